// file: rtl/ppsl_link.sv
// Overview of operation
// R1: transmitter takes 21-bit colour plus control word
// R2: word sampled on pixel clock rising edge
// R3: receiver drives the same 21-bit word
// R4: pixel clock output rising edge strobes word
// R5: transmitter power-down floats data and clock
// R6: receiver power-down freezes its parallel outputs
// R7: seven bits per channel per link clock
// R8: pin mapping is the system designer's choice
// R9: transmitter waits lock time before sending
// R10: identical fixed bit order on both ends
`timescale 1ns/1ps
module ppsl_link
   import ppsl_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES_P = PPSL_LOCK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // transmitter, controller side
   input wire ppsl_word_type tx_parallel_inputs,
   input wire logic pixel_clock_input,
   input wire logic tx_power_down_n,
   // transmitter, link side
   output logic [PPSL_CHANNELS-1:0] tx_serial_data_pairs,
   output logic [PPSL_CHANNELS-1:0] tx_serial_data_pairs_oe,
   output logic forwarded_clock_output,
   output logic forwarded_clock_output_oe,
   // receiver, link side
   input wire logic [PPSL_CHANNELS-1:0] rx_serial_data_pairs,
   input wire logic forwarded_clock_input,
   input wire logic rx_power_down_n,
   // receiver, panel side
   output ppsl_word_type rx_parallel_outputs,
   output logic pixel_clock_output
);

   // ---------------- transmitter ----------------
   logic [PPSL_WORD_BITS+1:0] tx_sync;
   ppsl_word_type tx_word_s;
   logic tx_pclk_s, tx_pd_s;

   ppsl_sync #(.WIDTH(PPSL_WORD_BITS + 2)) u_tx_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in({tx_power_down_n, pixel_clock_input, tx_parallel_inputs}),
      .sync_out(tx_sync)
   );

   assign tx_word_s = ppsl_word_type'(tx_sync[PPSL_WORD_BITS-1:0]);
   assign tx_pclk_s = tx_sync[PPSL_WORD_BITS];
   assign tx_pd_s = tx_sync[PPSL_WORD_BITS+1];

   ppsl_tx_state_type tx_state_q, tx_state_d;
   ppsl_word_type tx_word_q, tx_word_d;
   logic [2:0] tx_bit_q, tx_bit_d;
   logic [31:0] lock_cnt_q, lock_cnt_d;
   logic tx_pclk_prev_q, tx_pclk_rise;
   logic [PPSL_CHANNELS-1:0] tx_data_q, tx_data_d;
   logic tx_fwd_q, tx_fwd_d, tx_oe_q;

   assign tx_pclk_rise = tx_pclk_s & ~tx_pclk_prev_q;

   always_comb begin
      tx_state_d = tx_state_q;
      tx_word_d = tx_word_q;
      tx_bit_d = tx_bit_q;
      lock_cnt_d = lock_cnt_q;
      tx_data_d = '0;
      tx_fwd_d = 1'b0;
      if (!tx_pd_s) begin
         // relock from scratch after every power-down
         tx_state_d = TX_OFF; // see R5
         lock_cnt_d = '0;
      end else begin
         unique case (tx_state_q)
            TX_OFF: begin
               if (lock_cnt_q >= LOCK_CYCLES_P - 32'h1) begin
                  tx_state_d = TX_IDLE; // see R9
               end else begin
                  lock_cnt_d = lock_cnt_q + 32'h1;
               end
            end
            TX_IDLE: begin
               if (tx_pclk_rise) begin
                  tx_word_d = tx_word_s; // see R2
                  tx_bit_d = 3'h0;
                  tx_state_d = TX_SHIFT;
                  tx_data_d = ppsl_slot_bits(tx_word_s, 3'h0); // see R10
                  tx_fwd_d = 1'b1;
               end
            end
            TX_SHIFT: begin
               // a pixel edge that lands inside a slot is dropped
               if (tx_bit_q == PPSL_LAST_BIT) begin
                  tx_state_d = TX_IDLE;
               end else begin
                  tx_bit_d = tx_bit_q + 3'h1;
                  tx_data_d = ppsl_slot_bits(tx_word_q, tx_bit_d); // see R7
                  tx_fwd_d = (int'(tx_bit_d) < PPSL_FWD_HIGH_BITS);
               end
            end
            default: begin
               tx_state_d = TX_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_state_q <= TX_OFF;
         tx_word_q <= '0;
         tx_bit_q <= 3'h0;
         lock_cnt_q <= '0;
         tx_pclk_prev_q <= 1'b0;
         tx_data_q <= '0;
         tx_fwd_q <= 1'b0;
         tx_oe_q <= 1'b0;
      end else begin
         tx_state_q <= tx_state_d;
         tx_word_q <= tx_word_d;
         tx_bit_q <= tx_bit_d;
         lock_cnt_q <= lock_cnt_d;
         tx_pclk_prev_q <= tx_pclk_s;
         tx_data_q <= tx_data_d;
         tx_fwd_q <= tx_fwd_d;
         tx_oe_q <= tx_pd_s; // see R5
      end
   end

   assign tx_serial_data_pairs = tx_data_q;
   assign tx_serial_data_pairs_oe = {PPSL_CHANNELS{tx_oe_q}};
   assign forwarded_clock_output = tx_fwd_q;
   assign forwarded_clock_output_oe = tx_oe_q;

   // ---------------- receiver ----------------
   logic [1:0] rx_sync;
   logic [PPSL_CHANNELS-1:0] rx_data_s;
   logic rx_fwd_s, rx_pd_s;
   // a serial bit lasts one cycle, too short for the agreement filter, so the
   // data lines take four plain stages matching the filtered link clock delay
   logic [3:0][PPSL_CHANNELS-1:0] rx_dly_q, rx_dly_d;

   ppsl_sync #(.WIDTH(2)) u_rx_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .async_in({rx_power_down_n, forwarded_clock_input}),
      .sync_out(rx_sync)
   );

   always_comb begin
      rx_dly_d = {rx_dly_q[2:0], rx_serial_data_pairs};
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_dly_q <= '0;
      end else begin
         rx_dly_q <= rx_dly_d;
      end
   end

   assign rx_data_s = rx_dly_q[3];
   assign rx_fwd_s = rx_sync[0];
   assign rx_pd_s = rx_sync[1];

   ppsl_slots_type rx_sh_q, rx_sh_d;
   logic [2:0] rx_bit_q, rx_bit_d, rx_hold_q, rx_hold_d;
   logic rx_busy_q, rx_busy_d, rx_done_q, rx_done_d;
   logic rx_fwd_prev_q, rx_fwd_rise, rx_pclk_q, rx_pclk_d;
   ppsl_word_type rx_word_q, rx_word_d;

   assign rx_fwd_rise = rx_fwd_s & ~rx_fwd_prev_q;

   always_comb begin
      rx_sh_d = rx_sh_q;
      rx_bit_d = rx_bit_q;
      rx_busy_d = rx_busy_q;
      rx_done_d = 1'b0;
      if (!rx_busy_q && rx_fwd_rise) begin
         // link clock rising edge marks bit 0 of the slot
         for (int c = 0; c < PPSL_CHANNELS; c++) begin
            rx_sh_d[c][0] = rx_data_s[c];
         end
         rx_bit_d = 3'h1;
         rx_busy_d = 1'b1;
      end else if (rx_busy_q) begin
         for (int c = 0; c < PPSL_CHANNELS; c++) begin
            rx_sh_d[c][rx_bit_q] = rx_data_s[c]; // see R7
         end
         if (rx_bit_q == PPSL_LAST_BIT) begin
            rx_busy_d = 1'b0;
            rx_done_d = 1'b1;
         end else begin
            rx_bit_d = rx_bit_q + 3'h1;
         end
      end
   end

   // data moves first, the strobe rises one cycle later
   always_comb begin
      rx_word_d = rx_word_q;
      rx_hold_d = rx_hold_q;
      rx_pclk_d = rx_pclk_q;
      if (rx_pd_s) begin // see R6
         if (rx_done_q) begin
            rx_word_d = ppsl_assemble(rx_sh_q); // see R3
            rx_hold_d = PPSL_PCLK_HIGH_CYC;
         end else if (rx_hold_q != 3'h0) begin
            rx_hold_d = rx_hold_q - 3'h1;
         end
         rx_pclk_d = (rx_hold_q != 3'h0); // see R4
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_sh_q <= '0;
         rx_bit_q <= 3'h0;
         rx_busy_q <= 1'b0;
         rx_done_q <= 1'b0;
         rx_fwd_prev_q <= 1'b0;
         rx_word_q <= '0;
         rx_hold_q <= 3'h0;
         rx_pclk_q <= 1'b0;
      end else begin
         rx_sh_q <= rx_sh_d;
         rx_bit_q <= rx_bit_d;
         rx_busy_q <= rx_busy_d;
         rx_done_q <= rx_done_d;
         rx_fwd_prev_q <= rx_fwd_s;
         rx_word_q <= rx_word_d;
         rx_hold_q <= rx_hold_d;
         rx_pclk_q <= rx_pclk_d;
      end
   end

   assign rx_parallel_outputs = rx_word_q;
   assign pixel_clock_output = rx_pclk_q;

   // ---------------- checks ----------------
   sequence fwd_high_part;
      tx_fwd_q [*4];
   endsequence
   sequence fwd_low_part;
      !tx_fwd_q [*3];
   endsequence

   AST_TX_CAPTURE: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R2
      (tx_state_q == TX_IDLE && tx_pd_s && tx_pclk_rise) |=> (tx_word_q == $past(tx_word_s)))
      else $error("pixel word not captured on pixel clock edge");
   AST_TX_FIRST_BIT: assert property (@(posedge sys_clk) disable iff (!reset_n || !tx_pd_s) // see R1
      (tx_state_q == TX_IDLE && tx_pd_s && tx_pclk_rise)
      |=> (tx_data_q == ppsl_slot_bits(tx_word_q, 3'h0)) ##6
      (tx_data_q == ppsl_slot_bits(tx_word_q, 3'h6)))
      else $error("serial slot does not carry the captured word");
   AST_TX_SEVEN: assert property (@(posedge sys_clk) disable iff (!reset_n || !tx_pd_s) // see R7
      (tx_state_q == TX_IDLE && tx_pclk_rise) |=> fwd_high_part ##1 fwd_low_part)
      else $error("forwarded clock is not four high and three low bits");
   AST_TX_FLOAT: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R5
      !tx_pd_s |=> (tx_serial_data_pairs_oe == '0 && !forwarded_clock_output_oe))
      else $error("outputs driven during power-down");
   AST_TX_LOCK: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R9
      (tx_state_q == TX_OFF && lock_cnt_q < LOCK_CYCLES_P - 32'h2)
      |=> (tx_state_q == TX_OFF) ##1 (!tx_fwd_q && tx_data_q == '0))
      else $error("transmitter sent before lock time elapsed");
   AST_RX_SEVEN: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R7
      (!rx_busy_q && rx_fwd_rise) |-> ##7 rx_done_q)
      else $error("receiver slot is not seven bits long");
   AST_RX_WORD: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R10
      (rx_done_q && rx_pd_s) |=> (rx_parallel_outputs == $past(ppsl_assemble(rx_sh_q))))
      else $error("recovered word does not match received bits");
   AST_RX_STROBE: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R4
      $rose(pixel_clock_output) |-> $stable(rx_parallel_outputs))
      else $error("output word changed on strobe edge");
   AST_RX_FREEZE: assert property (@(posedge sys_clk) disable iff (!reset_n) // see R6
      !rx_pd_s |=> ($stable(rx_parallel_outputs) && $stable(pixel_clock_output)))
      else $error("receiver outputs moved during power-down");

endmodule // ppsl_link

// file: shared/ppsl_pkg.sv
package ppsl_pkg;

   // one pixel word as it travels across the link
   typedef struct packed {
      logic line_sync;
      logic frame_sync;
      logic pixel_data_valid;
      logic [5:0] blue;
      logic [5:0] green;
      logic [5:0] red;
   } ppsl_word_type;

   localparam int PPSL_WORD_BITS = 21;
   localparam int PPSL_CHANNELS = 3;
   localparam int PPSL_SLOT_BITS = 7;
   // forwarded clock is high for the first four bit times of a slot
   localparam int PPSL_FWD_HIGH_BITS = 4;
   localparam logic [2:0] PPSL_LAST_BIT = 3'h6;
   localparam logic [2:0] PPSL_PCLK_HIGH_CYC = 3'h3;

   localparam int PPSL_SYS_CLK_MHZ = 100;
   localparam int PPSL_LOCK_TIME_MS = 10;
   // longest wait, rounded down to whole cycles
   localparam int PPSL_LOCK_CYCLES = PPSL_LOCK_TIME_MS * 1000 * PPSL_SYS_CLK_MHZ;

   typedef logic [PPSL_CHANNELS-1:0][PPSL_SLOT_BITS-1:0] ppsl_slots_type;

   typedef enum logic [2:0] {
      TX_OFF = 3'b001,
      TX_IDLE = 3'b010,
      TX_SHIFT = 3'b100
   } ppsl_tx_state_type;

   // channel c carries word bits c*7 .. c*7+6, bit 0 of the slot first
   function automatic logic [PPSL_CHANNELS-1:0] ppsl_slot_bits(input ppsl_word_type w,
                                                              input logic [2:0] k);
      logic [PPSL_CHANNELS-1:0] b;
      b = '0;
      for (int c = 0; c < PPSL_CHANNELS; c++) begin
         b[c] = w[c * PPSL_SLOT_BITS + int'(k)];
      end
      return b;
   endfunction

   function automatic ppsl_word_type ppsl_assemble(input ppsl_slots_type s);
      logic [PPSL_WORD_BITS-1:0] w;
      w = '0;
      for (int c = 0; c < PPSL_CHANNELS; c++) begin
         for (int k = 0; k < PPSL_SLOT_BITS; k++) begin
            w[c * PPSL_SLOT_BITS + k] = s[c][k];
         end
      end
      return ppsl_word_type'(w);
   endfunction

endpackage

// file: rtl/ppsl_sync.sv
`timescale 1ns/1ps
module ppsl_sync
   import ppsl_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // pins
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

   // a bit only moves once the second and third stages agree
   always_comb begin
      out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         out_q <= '0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;

endmodule // ppsl_sync

// file: bench/ppsl_ctrl_model.sv
`timescale 1ns/1ps
module ppsl_ctrl_model
   import ppsl_pkg::*;
(
   // clock and bench request
   input wire logic sys_clk,
   input wire logic go,
   input wire ppsl_word_type word_in,
   output logic busy = 1'b0,
   // controller pins
   output ppsl_word_type tx_parallel_inputs = '0,
   output logic pixel_clock_input = 1'b0,
   // cable
   input wire logic [PPSL_CHANNELS-1:0] tx_serial_data_pairs,
   input wire logic [PPSL_CHANNELS-1:0] tx_serial_data_pairs_oe,
   input wire logic forwarded_clock_output,
   input wire logic forwarded_clock_output_oe,
   output logic [PPSL_CHANNELS-1:0] rx_serial_data_pairs,
   output logic forwarded_clock_input
);
   int cnt = 0;
   logic start;
   logic idle_pat = 1'b0;
   // released lines toggle so a stale bit cannot pass as data
   assign rx_serial_data_pairs = (tx_serial_data_pairs & tx_serial_data_pairs_oe) |
                                 ({PPSL_CHANNELS{idle_pat}} & ~tx_serial_data_pairs_oe);
   // link clock stands still while released
   assign forwarded_clock_input = forwarded_clock_output & forwarded_clock_output_oe;
   // word set two cycles before the rise, held six after it; 80 ns period
   always @(posedge sys_clk) begin
      start = (cnt == 0) && go;
      idle_pat <= ~idle_pat;
      #1;
      if (start) begin
         busy = 1'b1;
         tx_parallel_inputs = word_in;
         cnt = 1;
      end else if (cnt != 0) begin
         cnt++;
         pixel_clock_input = (cnt >= 3) && (cnt < 7);
         if (cnt == 7) begin
            cnt = 0;
            busy = 1'b0;
         end
      end
   end
endmodule // ppsl_ctrl_model

// file: bench/ppsl_link_bench.sv
`timescale 1ns/1ps
module ppsl_link_bench;
   import ppsl_pkg::*;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic tx_power_down_n = 1'b1;
   logic rx_power_down_n = 1'b1;
   logic go = 1'b0;
   logic busy;
   logic expect_on = 1'b0;
   logic pco_q = 1'b0;
   ppsl_word_type word_in = '0;
   ppsl_word_type tx_parallel_inputs, rx_parallel_outputs, frozen;
   logic pixel_clock_input, forwarded_clock_output, forwarded_clock_output_oe;
   logic forwarded_clock_input, pixel_clock_output;
   logic [PPSL_CHANNELS-1:0] tx_serial_data_pairs, tx_serial_data_pairs_oe, rx_serial_data_pairs;
   ppsl_word_type exp_q[$];
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   int hi_cnt = 0;

   always #5 sys_clk = ~sys_clk;

   ppsl_link #(.LOCK_CYCLES_P(20)) dut (
      .sys_clk(sys_clk), .reset_n(reset_n),
      .tx_parallel_inputs(tx_parallel_inputs), .pixel_clock_input(pixel_clock_input),
      .tx_power_down_n(tx_power_down_n), .tx_serial_data_pairs(tx_serial_data_pairs),
      .tx_serial_data_pairs_oe(tx_serial_data_pairs_oe),
      .forwarded_clock_output(forwarded_clock_output),
      .forwarded_clock_output_oe(forwarded_clock_output_oe),
      .rx_serial_data_pairs(rx_serial_data_pairs), .forwarded_clock_input(forwarded_clock_input),
      .rx_power_down_n(rx_power_down_n), .rx_parallel_outputs(rx_parallel_outputs),
      .pixel_clock_output(pixel_clock_output));

   ppsl_ctrl_model partner (
      .sys_clk(sys_clk), .go(go), .word_in(word_in), .busy(busy),
      .tx_parallel_inputs(tx_parallel_inputs), .pixel_clock_input(pixel_clock_input),
      .tx_serial_data_pairs(tx_serial_data_pairs),
      .tx_serial_data_pairs_oe(tx_serial_data_pairs_oe),
      .forwarded_clock_output(forwarded_clock_output),
      .forwarded_clock_output_oe(forwarded_clock_output_oe),
      .rx_serial_data_pairs(rx_serial_data_pairs), .forwarded_clock_input(forwarded_clock_input));

   task automatic chk(input string nm, input logic [PPSL_WORD_BITS-1:0] e,
                      input logic [PPSL_WORD_BITS-1:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic results();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // one pixel period; the note is queued only when a strobe is due
   task automatic pix(input ppsl_word_type w);
      int t = 0;
      if (expect_on) exp_q.push_back(w);
      word_in = w;
      go = 1'b1;
      @(posedge sys_clk);
      #1 go = 1'b0;
      do begin
         @(posedge sys_clk);
         t++;
      end while (busy === 1'b1 && t < 50);
      #1;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      pco_q <= pixel_clock_output;
      if (pixel_clock_output === 1'b1 && pco_q === 1'b0) begin
         if (exp_q.size() == 0) begin
            check_count++;
            n_errors++;
            $display("BAD strobe expected none seen %h", rx_parallel_outputs);
         end else begin
            chk("rx word", exp_q.pop_front(), rx_parallel_outputs);
         end
      end
      if (forwarded_clock_output === 1'b1) begin
         hi_cnt <= hi_cnt + 1;
      end else if (hi_cnt != 0) begin
         chk("fwd high", 21'(PPSL_FWD_HIGH_BITS), 21'(hi_cnt));
         hi_cnt <= 0;
      end
      if (cycles == 3000) begin
         n_errors++;
         results();
      end
   end

   initial begin
      void'($urandom(16));
      repeat (12) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      idle(60);
      expect_on = 1'b1;
      pix('0);
      pix('1);
      for (int i = 0; i < PPSL_WORD_BITS; i++) pix(ppsl_word_type'(21'h1 << i));
      repeat (20) pix(ppsl_word_type'(21'($urandom)));
      idle(30);
      chk("pending words", '0, 21'(exp_q.size()));
      rx_power_down_n = 1'b0;
      idle(6);
      frozen = rx_parallel_outputs;
      expect_on = 1'b0;
      repeat (3) pix(ppsl_word_type'(21'($urandom)));
      idle(20);
      chk("frozen word", frozen, rx_parallel_outputs);
      rx_power_down_n = 1'b1;
      idle(20);
      expect_on = 1'b1;
      pix(ppsl_word_type'(21'h0aa55a));
      // let the slot finish before floating the link
      idle(20);
      tx_power_down_n = 1'b0;
      idle(6);
      chk("oe off", '0, 21'({forwarded_clock_output_oe, tx_serial_data_pairs_oe}));
      expect_on = 1'b0;
      pix('1);
      tx_power_down_n = 1'b1;
      idle(6);
      chk("oe on", 21'hf, 21'({forwarded_clock_output_oe, tx_serial_data_pairs_oe}));
      // still locking, so this word must be dropped
      pix('1);
      idle(40);
      expect_on = 1'b1;
      pix(ppsl_word_type'(21'($urandom)));
      pix('0);
      idle(30);
      chk("pending words", '0, 21'(exp_q.size()));
      results();
   end
endmodule // ppsl_link_bench
